// ==== smp_prog_port.v ====
// Serial in-system programming port with its command FIFO and memory arrays.
`timescale 1ns/100ps
// What this block does
// RL1: Programming only while reset low or entry strap caught, enable first.
// RL2: Serial data on dedicated pins, clock on SPI.
// RL3: EEPROM write erases its byte automatically.
// RL4: Chip erase sets both arrays to 0xFF.
// RL5: Programmer holds clock phases over two cycles.
// RL6: Input bit sampled on clock rising edge.
// RL7: Output bit changes on clock falling edge.
// RL8: Programmer powers up with reset, clock low; the bench holds reset_pin_n high for the first 20 cycles.
// RL9: Entry pin low at power-on also enters.
// RL10: Programmer waits 20 ms before enabling; the bench waits 64 cycles.
// RL11: Second enable byte echoes during third byte.
// RL12: Programmer always shifts four bytes, retries; the model never retries a frame.
// RL13: Page loaded per byte, low before high.
// RL14: Write-page commits buffer to addressed page.
// RL15: Programmer waits page delay before next page.
// RL16: EEPROM written one byte per instruction.
// RL17: Reads return data within same frame.
// RL18: Reset high ends programming mode unless the entry strap was caught.
// RL19: Programmer only polls during a write.
// RL20: Waits are 4.5 ms and 9.0 ms.
// RL21: Page under write reads 0xFF until done.
// RL22: Enable is 0xAC then 0x53, rest ignored.
// RL23: Frames are 32 bits, MSB first, reset clears.
// RL24: Ignore everything until enable is received.
`include "smp_defs.vh"

module smp_fifo #(
   parameter W = 8,
   parameter AW = 3
) (
   input wire clk,
   input wire sys_rst,
   input wire in_valid,
   output wire in_ready,
   input wire [W-1:0] in_data,
   output wire out_valid,
   input wire out_ready,
   output wire [W-1:0] out_data
);
   reg [W-1:0] mem [0:(1<<AW)-1];
   reg [AW:0] wr_ptr_reg, rd_ptr_reg;
   wire empty, full;
   // Extra pointer bit tells a full FIFO from an empty one.
   assign empty = (wr_ptr_reg == rd_ptr_reg);
   assign full = (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]) && (wr_ptr_reg[AW] != rd_ptr_reg[AW]);
   assign in_ready = ~full;
   assign out_valid = ~empty;
   assign out_data = mem[rd_ptr_reg[AW-1:0]];
   // Pointers advance only on an accepted handshake.
   always @(posedge clk) begin
      if (sys_rst) begin
         wr_ptr_reg <= {(AW+1){1'b0}};
         rd_ptr_reg <= {(AW+1){1'b0}};
      end else begin
         if (in_valid && !full) begin
            mem[wr_ptr_reg[AW-1:0]] <= in_data;
            wr_ptr_reg <= wr_ptr_reg + 1'b1;
         end
         if (out_ready && !empty) begin
            rd_ptr_reg <= rd_ptr_reg + 1'b1;
         end
      end
   end
endmodule // smp_fifo

module smp_prog_port #(
   parameter FLASH_WAIT_CYC = `SMP_FLASH_WAIT_NS / `SMP_CLK_NS,
   parameter EEPROM_WAIT_CYC = `SMP_EEPROM_WAIT_NS / `SMP_CLK_NS,
   parameter ERASE_WAIT_CYC = `SMP_ERASE_WAIT_NS / `SMP_CLK_NS,
   parameter FLASH_AW = 15,
   parameter PAGE_AW = 7,
   parameter EE_AW = 11,
   parameter FIFO_AW = 3
) (
   input wire clk,
   input wire sys_rst,
   input wire reset_pin_n,
   input wire prog_entry_pin_n,
   input wire port_b_bit1,
   input wire prog_serial_in,
   output wire prog_serial_out,
   output wire prog_serial_out_oe,
   output wire prog_mode,
   output wire write_busy,
   output reg cmd_dropped_reg
);
   localparam ST_IDLE = 2'h0, ST_FLASH = 2'h1, ST_EEWR = 2'h2, ST_ERASE = 2'h3;
   localparam [23:0] FL_LIM = FLASH_WAIT_CYC[23:0] - 24'h000001;
   localparam [23:0] EE_LIM = EEPROM_WAIT_CYC[23:0] - 24'h000001;
   localparam [23:0] ER_LIM = ERASE_WAIT_CYC[23:0] - 24'h000001;
   localparam [23:0] PAGE_WORDS = 24'h000001 << PAGE_AW;
   localparam [23:0] FLASH_WORDS = 24'h000001 << FLASH_AW;
   localparam [23:0] EE_BYTES = 24'h000001 << EE_AW;
   reg [7:0] flash_lo [0:(1<<FLASH_AW)-1];
   reg [7:0] flash_hi [0:(1<<FLASH_AW)-1];
   reg [7:0] ee_mem [0:(1<<EE_AW)-1];
   reg [7:0] pbuf_lo [0:(1<<PAGE_AW)-1];
   reg [7:0] pbuf_hi [0:(1<<PAGE_AW)-1];
   reg [3:0] sync1_reg, sync2_reg;
   reg sck_d_reg, pen_mode_reg, enabled_reg, load_reg, push_v_reg;
   reg [1:0] strap_cnt_reg, st_reg;
   reg [4:0] bit_cnt_reg;
   reg [30:0] shift_reg;
   reg [7:0] pend_reg, out_sh_reg;
   reg [`SMP_CMD_W-1:0] push_d_reg;
   reg [23:0] wcnt_reg;
   reg [FLASH_AW-PAGE_AW-1:0] page_reg;
   reg [EE_AW-1:0] ee_addr_reg;
   wire act, sck_rise, sck_fall, din, in_ready, q_valid, q_hi;
   wire [31:0] frame;
   wire [7:0] b1, b2, b3, q_data;
   wire [14:0] rd_word, q_addr;
   wire [FLASH_AW-1:0] rd_faddr;
   wire [EE_AW-1:0] rd_eaddr;
   wire [`SMP_CMD_W-1:0] q_d;
   wire [1:0] q_op;
   reg [7:0] rd_data;
   reg rd_hit, cmd_v;
   reg [`SMP_CMD_W-1:0] cmd_d;
   // Pins cross through two flip-flops, also in reset, so a strap held then is settled.
   always @(posedge clk) begin
      sync1_reg <= {prog_entry_pin_n, reset_pin_n, prog_serial_in, port_b_bit1}; // see RL2
      sync2_reg <= sync1_reg;
      sck_d_reg <= sync2_reg[0];
   end
   assign sck_rise = sync2_reg[0] & ~sck_d_reg;
   assign sck_fall = ~sync2_reg[0] & sck_d_reg;
   assign din = sync2_reg[1];
   // The entry pin counts only once, just after power-on reset settles.
   always @(posedge clk) begin
      if (sys_rst) begin
         strap_cnt_reg <= 2'h0;
         pen_mode_reg <= 1'b0;
      end else if (strap_cnt_reg != `SMP_STRAP_CNT) begin
         strap_cnt_reg <= strap_cnt_reg + 2'h1;
         if (strap_cnt_reg + 2'h1 == `SMP_STRAP_CNT) begin
            pen_mode_reg <= ~sync2_reg[3]; // see RL9
         end
      end
   end
   // Programming mode lasts while reset is low or the strap was caught.
   assign act = ~sync2_reg[2] | pen_mode_reg; // see RL1 see RL18
   assign prog_mode = act;
   assign prog_serial_out = out_sh_reg[7];
   assign prog_serial_out_oe = act;
   assign write_busy = (st_reg != ST_IDLE);
   // Fields of the frame as it stands after the current sampled bit.
   assign frame = {shift_reg, din};
   assign b1 = shift_reg[22:15];
   assign b2 = shift_reg[14:7];
   assign b3 = frame[7:0];
   assign rd_word = {b2[6:0], b3};
   assign rd_faddr = rd_word[FLASH_AW-1:0];
   assign rd_eaddr = rd_word[EE_AW-1:0];
   // Read data, forced to the erased value while its location is busy.
   always @* begin
      rd_hit = enabled_reg;
      rd_data = `SMP_ERASED;
      if (b1 == `SMP_OP_RD_LO || b1 == `SMP_OP_RD_HI) begin
         if (!(st_reg == ST_ERASE) &&
             !(st_reg == ST_FLASH && rd_faddr[FLASH_AW-1:PAGE_AW] == page_reg)) begin
            rd_data = b1[3] ? flash_hi[rd_faddr] : flash_lo[rd_faddr]; // see RL21
         end
      end else if (b1 == `SMP_OP_EE_RD) begin
         if (!(st_reg == ST_ERASE) && !(st_reg == ST_EEWR && rd_eaddr == ee_addr_reg)) begin
            rd_data = ee_mem[rd_eaddr];
         end
      end else begin
         rd_hit = 1'b0;
      end
   end
   // Decode of a whole frame into a queued memory command.
   always @* begin
      cmd_v = 1'b0;
      cmd_d = {`SMP_CMD_W{1'b0}};
      if (enabled_reg) begin // see RL24
         if (frame[31:24] == `SMP_OP_ENTER && frame[23:21] == `SMP_ERASE_B2) begin
            cmd_v = 1'b1;
            cmd_d = {`SMP_CMD_ERASE, 1'b0, 15'h0000, 8'h00};
         end else if (frame[31:24] == `SMP_OP_LOAD_LO || frame[31:24] == `SMP_OP_LOAD_HI) begin
            cmd_v = 1'b1; // see RL13
            cmd_d = {`SMP_CMD_LOAD, frame[27], 8'h00, frame[14:8], frame[7:0]};
         end else if (frame[31:24] == `SMP_OP_WPAGE) begin
            cmd_v = 1'b1;
            cmd_d = {`SMP_CMD_WPAGE, 1'b0, frame[22:16], frame[15], 7'h00, 8'h00};
         end else if (frame[31:24] == `SMP_OP_EE_WR) begin
            cmd_v = 1'b1; // see RL16
            cmd_d = {`SMP_CMD_EEWR, 1'b0, 4'h0, frame[18:16], frame[15:8], frame[7:0]};
         end
      end
   end
   // Link shifter: sample on rising, shift out on falling edges.
   always @(posedge clk) begin
      if (sys_rst || !act) begin
         bit_cnt_reg <= 5'h00; // see RL23
         shift_reg <= 31'h00000000;
         pend_reg <= 8'h00;
         load_reg <= 1'b0;
         out_sh_reg <= 8'h00;
         enabled_reg <= 1'b0;
         push_v_reg <= 1'b0;
         push_d_reg <= {`SMP_CMD_W{1'b0}};
         cmd_dropped_reg <= 1'b0;
      end else begin
         push_v_reg <= 1'b0;
         if (push_v_reg && !in_ready) begin
            cmd_dropped_reg <= 1'b1;
         end
         if (sck_rise) begin
            shift_reg <= frame[30:0]; // see RL6
            bit_cnt_reg <= bit_cnt_reg + 5'h01;
            if (bit_cnt_reg[2:0] == `SMP_BYTE_LAST) begin
               load_reg <= 1'b1;
               // Each byte echoes the one before it, unless a read answers.
               if (bit_cnt_reg == `SMP_RD_BIT && rd_hit) begin
                  pend_reg <= rd_data; // see RL17
               end else begin
                  pend_reg <= b3; // see RL11
               end
            end
            if (bit_cnt_reg == `SMP_FRAME_LAST) begin
               if (frame[31:24] == `SMP_OP_ENTER && frame[23:16] == `SMP_OP_ENTER2) begin
                  enabled_reg <= 1'b1; // see RL22 see RL1
               end
               push_v_reg <= cmd_v;
               push_d_reg <= cmd_d;
            end
         end else if (sck_fall) begin
            if (load_reg) begin
               out_sh_reg <= pend_reg; // see RL7
               load_reg <= 1'b0;
            end else begin
               out_sh_reg <= {out_sh_reg[6:0], 1'b0};
            end
         end
      end
   end
   smp_fifo #(
      .W(`SMP_CMD_W),
      .AW(FIFO_AW)
   ) u_fifo (
      .clk(clk),
      .sys_rst(sys_rst),
      .in_valid(push_v_reg),
      .in_ready(in_ready),
      .in_data(push_d_reg),
      .out_valid(q_valid),
      .out_ready(st_reg == ST_IDLE),
      .out_data(q_d)
   );
   assign q_op = q_d[25:24];
   assign q_hi = q_d[23];
   assign q_addr = q_d[22:8];
   assign q_data = q_d[7:0];
   // Memory engine: runs queued commands, self-timed writes stall the queue.
   always @(posedge clk) begin
      if (sys_rst) begin
         st_reg <= ST_IDLE;
         wcnt_reg <= 24'h000000;
         page_reg <= {(FLASH_AW-PAGE_AW){1'b0}};
         ee_addr_reg <= {EE_AW{1'b0}};
      end else begin
         case (st_reg)
            ST_IDLE: begin
               wcnt_reg <= 24'h000000;
               if (q_valid) begin
                  case (q_op)
                     `SMP_CMD_LOAD: begin
                        if (q_hi) begin
                           pbuf_hi[q_addr[PAGE_AW-1:0]] <= q_data; // see RL13
                        end else begin
                           pbuf_lo[q_addr[PAGE_AW-1:0]] <= q_data;
                        end
                     end
                     `SMP_CMD_WPAGE: begin
                        page_reg <= q_addr[FLASH_AW-1:PAGE_AW]; // see RL14
                        st_reg <= ST_FLASH;
                     end
                     `SMP_CMD_EEWR: begin
                        // Overwriting the byte is its erase and write in one step.
                        ee_mem[q_addr[EE_AW-1:0]] <= q_data; // see RL3
                        ee_addr_reg <= q_addr[EE_AW-1:0];
                        st_reg <= ST_EEWR;
                     end
                     default: begin
                        st_reg <= ST_ERASE;
                     end
                  endcase
               end
            end
            ST_FLASH: begin
               // Copy one word per cycle, refilling that buffer slot with ones in the same cycle.
               if (wcnt_reg < PAGE_WORDS) begin
                  flash_lo[{page_reg, wcnt_reg[PAGE_AW-1:0]}] <= pbuf_lo[wcnt_reg[PAGE_AW-1:0]];
                  flash_hi[{page_reg, wcnt_reg[PAGE_AW-1:0]}] <= pbuf_hi[wcnt_reg[PAGE_AW-1:0]];
                  pbuf_lo[wcnt_reg[PAGE_AW-1:0]] <= `SMP_ERASED;
                  pbuf_hi[wcnt_reg[PAGE_AW-1:0]] <= `SMP_ERASED;
               end
               if (wcnt_reg >= FL_LIM && wcnt_reg >= PAGE_WORDS) begin
                  st_reg <= ST_IDLE; // see RL14
               end else begin
                  wcnt_reg <= wcnt_reg + 24'h000001;
               end
            end
            ST_EEWR: begin
               if (wcnt_reg >= EE_LIM) begin
                  st_reg <= ST_IDLE;
               end else begin
                  wcnt_reg <= wcnt_reg + 24'h000001;
               end
            end
            default: begin
               // Sweep both arrays to the erased value, one location per cycle.
               if (wcnt_reg < FLASH_WORDS) begin
                  flash_lo[wcnt_reg[FLASH_AW-1:0]] <= `SMP_ERASED; // see RL4
                  flash_hi[wcnt_reg[FLASH_AW-1:0]] <= `SMP_ERASED;
               end
               if (wcnt_reg < EE_BYTES) begin
                  ee_mem[wcnt_reg[EE_AW-1:0]] <= `SMP_ERASED; // see RL4
               end
               if (wcnt_reg >= ER_LIM && wcnt_reg >= FLASH_WORDS && wcnt_reg >= EE_BYTES) begin
                  st_reg <= ST_IDLE;
               end else begin
                  wcnt_reg <= wcnt_reg + 24'h000001;
               end
            end
         endcase
      end
   end
endmodule // smp_prog_port

// ==== smp_defs.vh ====
// Constants of the serial memory programming port.
`ifndef SMP_DEFS_VH
`define SMP_DEFS_VH
`define SMP_CLK_NS 100
`define SMP_FLASH_WAIT_NS 4500000
`define SMP_EEPROM_WAIT_NS 9000000
`define SMP_ERASE_WAIT_NS 9000000
`define SMP_OP_ENTER 8'hac
`define SMP_OP_ENTER2 8'h53
`define SMP_ERASE_B2 3'h4
`define SMP_OP_LOAD_LO 8'h40
`define SMP_OP_LOAD_HI 8'h48
`define SMP_OP_WPAGE 8'h4c
`define SMP_OP_RD_LO 8'h20
`define SMP_OP_RD_HI 8'h28
`define SMP_OP_EE_RD 8'ha0
`define SMP_OP_EE_WR 8'hc0
`define SMP_ERASED 8'hff
`define SMP_BYTE_LAST 3'h7
`define SMP_RD_BIT 5'h17
`define SMP_FRAME_LAST 5'h1f
`define SMP_STRAP_CNT 2'h2
`define SMP_CMD_LOAD 2'h0
`define SMP_CMD_WPAGE 2'h1
`define SMP_CMD_EEWR 2'h2
`define SMP_CMD_ERASE 2'h3
`define SMP_CMD_W 26
`endif

// ==== smp_prog_port_monitor.sv ====
// Concurrent checks on the ports of the serial programming port.
`timescale 1ns/100ps
module smp_prog_port_monitor #(
   parameter FLASH_WAIT_CYC = 45000,
   parameter EEPROM_WAIT_CYC = 90000,
   parameter ERASE_WAIT_CYC = 90000
) (
   input wire clk,
   input wire sys_rst,
   input wire reset_pin_n,
   input wire prog_entry_pin_n,
   input wire port_b_bit1,
   input wire prog_serial_in,
   input wire prog_serial_out,
   input wire prog_serial_out_oe,
   input wire prog_mode,
   input wire write_busy,
   input wire cmd_dropped_reg
);
   localparam LIMIT = FLASH_WAIT_CYC + EEPROM_WAIT_CYC + ERASE_WAIT_CYC + 32768;
   reg [31:0] busy_cnt_reg;
   // Counts how long the self-timed engine has stayed busy without a break.
   always @(posedge clk) begin
      if (sys_rst || !write_busy) begin
         busy_cnt_reg <= 32'h0;
      end else begin
         busy_cnt_reg <= busy_cnt_reg + 32'h1;
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   // Pin ownership, output timing and self-timed write length.
   AST_OE_IS_MODE: assert property (prog_serial_out_oe == prog_mode)
      else $error("output enable differs from mode");
   AST_OUT_IDLE: assert property (!prog_mode [*3] |-> !prog_serial_out)
      else $error("serial out driven outside mode");
   AST_OUT_AFTER_FALL: assert property ($changed(prog_serial_out) && prog_mode && $past(prog_mode)
      |-> !$past(port_b_bit1, 2))
      else $error("serial out moved while clock high");
   AST_OUT_HOLD_HIGH: assert property ($rose(port_b_bit1) && prog_mode
      |-> $stable(prog_serial_out) [*3])
      else $error("serial out unstable around rising clock");
   AST_BUSY_MIN: assert property ($rose(write_busy) |-> write_busy [*8])
      else $error("write ended too soon");
   AST_BUSY_MAX: assert property (busy_cnt_reg <= LIMIT)
      else $error("write never ends");
   AST_MODE_FALL: assert property ($fell(prog_mode) |-> $past(reset_pin_n, 2))
      else $error("mode ended without reset pin high");
   AST_MODE_RISE: assert property ($rose(prog_mode)
      |-> !$past(reset_pin_n, 2) || $past(sys_rst, 3) || $past(sys_rst, 4))
      else $error("mode began without reset pin low");
   // Main scenarios reached.
   cover property ($rose(write_busy));
   cover property ($fell(prog_mode));
   cover property ($rose(cmd_dropped_reg));
endmodule // smp_prog_port_monitor

bind smp_prog_port smp_prog_port_monitor #(.FLASH_WAIT_CYC(FLASH_WAIT_CYC),
   .EEPROM_WAIT_CYC(EEPROM_WAIT_CYC), .ERASE_WAIT_CYC(ERASE_WAIT_CYC)) u_mon (.clk(clk),
   .sys_rst(sys_rst), .reset_pin_n(reset_pin_n), .prog_entry_pin_n(prog_entry_pin_n),
   .port_b_bit1(port_b_bit1), .prog_serial_in(prog_serial_in),
   .prog_serial_out(prog_serial_out), .prog_serial_out_oe(prog_serial_out_oe),
   .prog_mode(prog_mode), .write_busy(write_busy), .cmd_dropped_reg(cmd_dropped_reg));

// ==== smp_programmer_model.sv ====
// Programmer model that clocks instruction frames into the port.
`timescale 1ns/100ps
module smp_programmer_model (
   input wire clk,
   output reg port_b_bit1,
   output reg prog_serial_in,
   input wire prog_serial_out,
   output reg [31:0] rx_word,
   output reg rx_stb
);
   // The serial clock rests low between frames.
   initial begin
      port_b_bit1 = 1'b0;
      prog_serial_in = 1'b0;
      rx_word = 32'h0;
      rx_stb = 1'b0;
   end
   // Shifts all 32 bits MSB first, five cycles low and three high per bit.
   task frame(input [31:0] tx);
      integer i;
      begin
         for (i = 31; i >= 0; i = i - 1) begin
            @(negedge clk);
            port_b_bit1 = 1'b0;
            prog_serial_in = tx[i];
            repeat (5) @(negedge clk);
            port_b_bit1 = 1'b1;
            rx_word = {rx_word[30:0], prog_serial_out};
            repeat (2) @(negedge clk);
         end
         @(negedge clk);
         port_b_bit1 = 1'b0;
         rx_stb = 1'b1;
         @(negedge clk);
         rx_stb = 1'b0;
      end
   endtask
endmodule // smp_programmer_model

// ==== tb.sv ====
// Self-checking bench for the serial programming port.
`timescale 1ns/100ps
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin error_cnt++; \
   $display("wrong value %s exp %h got %h", nm, e, g); end end
module tb;
   reg clk = 1'b0;
   reg sys_rst = 1'b1;
   reg reset_pin_n = 1'b1;
   reg prog_entry_pin_n = 1'b1;
   wire sck, sdi, sdo, sdo_oe, prog_mode, write_busy, dropped, rx_stb;
   wire [31:0] rx_word;
   integer error_cnt = 0;
   integer checks = 0;
   integer seed = 5688;
   integer i;
   reg [31:0] exp_q[$];
   reg [31:0] e_now, r;
   reg [7:0] lo[0:3];
   reg [7:0] hi[0:3];
   reg [7:0] ea, d1;
   reg [1:0] pg;
   // Clock at 10 MHz.
   initial begin
      forever #50 clk = ~clk;
   end
   smp_prog_port #(.FLASH_WAIT_CYC(3000), .EEPROM_WAIT_CYC(2000), .ERASE_WAIT_CYC(100),
      .FLASH_AW(9), .EE_AW(8)) DUT (.clk(clk), .sys_rst(sys_rst),
      .reset_pin_n(reset_pin_n), .prog_entry_pin_n(prog_entry_pin_n), .port_b_bit1(sck),
      .prog_serial_in(sdi), .prog_serial_out(sdo), .prog_serial_out_oe(sdo_oe),
      .prog_mode(prog_mode), .write_busy(write_busy), .cmd_dropped_reg(dropped));
   smp_programmer_model u_prog (.clk(clk), .port_b_bit1(sck), .prog_serial_in(sdi),
      .prog_serial_out(sdo), .rx_word(rx_word), .rx_stb(rx_stb));
   // Notes the echo, or read data in byte four, then shifts the frame.
   task send(input [31:0] tx, input [7:0] rd, input rd_en);
      begin
         exp_q.push_back({8'h00, tx[31:16], rd_en ? rd : tx[15:8]});
         u_prog.frame(tx);
      end
   endtask
   // Waits, bounded, for the self-timed write to finish.
   task wait_idle;
      integer n;
      begin
         n = 0;
         repeat (8) @(negedge clk);
         `CHK("write_busy", 1'b1, write_busy)
         while (write_busy !== 1'b0 && n < 40000) begin
            @(negedge clk);
            n = n + 1;
         end
         `CHK("write_busy", 1'b0, write_busy)
      end
   endtask
   task stop_test;
      begin
         if (error_cnt == 0 && checks > 0) begin
            $display("[ PASS ]");
         end else begin
            $display("[ FAIL ]");
         end
         $finish;
      end
   endtask
   // Compares each finished frame against the oldest note.
   always @(posedge clk) begin
      if (rx_stb) begin
         e_now = exp_q.pop_front();
         `CHK("frame", e_now, rx_word & 32'h00ffffff)
      end
   end
   // Cuts a hang short.
   initial begin
      repeat (60000) @(posedge clk);
      error_cnt++;
      stop_test;
   end
   // Main sequence.
   initial begin
      repeat (16) @(negedge clk);
      sys_rst = 1'b0;
      repeat (4) @(negedge clk);
      reset_pin_n = 1'b0;
      repeat (64) @(negedge clk); // Entry wait shortened for simulation
      `CHK("prog_mode", 1'b1, prog_mode)
      `CHK("oe", 1'b1, sdo_oe)
      send(32'hac800000, 8'h0, 1'b0);
      repeat (20) @(negedge clk);
      `CHK("write_busy", 1'b0, write_busy)
      r = $random(seed);
      send({16'hac53, r[15:0]}, 8'h0, 1'b0);
      send(32'hac800000, 8'h0, 1'b0);
      wait_idle;
      for (i = 0; i < 3; i = i + 1) begin
         r = $random(seed);
         send({8'h20, 7'h00, r[8:0], 8'h00}, 8'hff, 1'b1);
         send({8'h28, 7'h00, r[17:9], 8'h00}, 8'hff, 1'b1);
         send({8'ha0, 8'h00, r[31:24], 8'h00}, 8'hff, 1'b1);
      end
      pg = r[19:18];
      for (i = 0; i < 4; i = i + 1) begin
         r = $random(seed);
         lo[i] = r[7:0];
         hi[i] = r[15:8];
         send({8'h40, 9'h000, i[1:0], 5'h00, lo[i]}, 8'h0, 1'b0);
         send({8'h48, 9'h000, i[1:0], 5'h00, hi[i]}, 8'h0, 1'b0);
      end
      send({8'h4c, 7'h00, pg, 15'h0000}, 8'h0, 1'b0);
      send({8'h20, 7'h00, pg, 7'h00, 8'h00}, 8'hff, 1'b1);
      wait_idle;
      for (i = 0; i < 4; i = i + 1) begin
         send({8'h20, 7'h00, pg, i[1:0], 5'h00, 8'h00}, lo[i], 1'b1);
         send({8'h28, 7'h00, pg, i[1:0], 5'h00, 8'h00}, hi[i], 1'b1);
      end
      r = $random(seed);
      ea = r[7:0];
      d1 = r[15:8];
      send({8'hc0, 8'h00, ea, d1}, 8'h0, 1'b0);
      send({8'ha0, 8'h00, ea, 8'h00}, 8'hff, 1'b1);
      wait_idle;
      send({8'ha0, 8'h00, ea, 8'h00}, d1, 1'b1);
      send({8'hc0, 8'h00, ea, ~d1}, 8'h0, 1'b0);
      wait_idle;
      send({8'ha0, 8'h00, ea, 8'h00}, ~d1, 1'b1);
      send({8'h4c, 24'h000000}, 8'h0, 1'b0);
      for (i = 0; i < 9; i = i + 1) begin
         send({8'h40, 24'h000000}, 8'h0, 1'b0);
         `CHK("dropped", (i == 8), dropped)
      end
      reset_pin_n = 1'b1;
      repeat (4) @(negedge clk);
      `CHK("prog_mode", 1'b0, prog_mode)
      `CHK("serial_out", 1'b0, sdo)
      `CHK("dropped", 1'b0, dropped)
      wait_idle;
      reset_pin_n = 1'b0;
      repeat (64) @(negedge clk);
      send({8'hc0, 8'h00, ea, d1}, 8'h0, 1'b0);
      repeat (20) @(negedge clk);
      `CHK("write_busy", 1'b0, write_busy)
      send(32'hac530000, 8'h0, 1'b0);
      send({8'ha0, 8'h00, ea, 8'h00}, ~d1, 1'b1);
      sys_rst = 1'b1;
      reset_pin_n = 1'b1;
      prog_entry_pin_n = 1'b0;
      repeat (16) @(negedge clk);
      sys_rst = 1'b0;
      repeat (8) @(negedge clk);
      prog_entry_pin_n = 1'b1;
      repeat (4) @(negedge clk);
      `CHK("prog_mode", 1'b1, prog_mode)
      send(32'hac530000, 8'h0, 1'b0);
      send({8'ha0, 8'h00, ea, 8'h00}, ~d1, 1'b1);
      repeat (4) @(negedge clk);
      stop_test;
   end
endmodule // tb
